// [rtl/sasr_pkg.sv]
// Notes on behaviour
// (RULE1) A falling edge on convert select starts a conversion and the transfer; the code starts only the transfer for an edge while busy.
// (RULE2) Output stays off until the fifth bit clock falling edge, then is low.
// (RULE3) Result then shifts out MSB first, one bit per later falling edge.
// (RULE4) Each bit holds across both bit clock edges; host may sample either.
// (RULE5) Converter powers down by itself after every conversion; the code stays awake in SASR_PUSH while the buffer is full.
// (RULE6) Result is two's complement, saturating at 7FFF and 8000.
// (RULE7) Bits shifted out belong to the conversion started by that same edge; the code sends the previous word after an edge ignored while busy.
// (RULE8) Host keeps select low for all sixteen bits; select high releases out.
package sasr_pkg;

  // ----------------------------------------------------------------
  // Widths and framing
  // ----------------------------------------------------------------
  localparam int DATA_W     = 16;
  localparam int IN_W       = 18;
  localparam int FIFO_DEPTH = 16;
  localparam int CNT_W      = 5;

  // Edge that turns the output on, and the edge that shifts out the last bit
  localparam logic [CNT_W-1:0] FIRST_EDGE = 5'h05;
  localparam logic [CNT_W-1:0] LAST_EDGE  = 5'h15;

  // ----------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] CODE_MAX = 16'h7FFF;
  localparam logic [DATA_W-1:0] CODE_MIN = 16'h8000;
  localparam logic [DATA_W-1:0] CODE_OFS = 16'h8000;
  localparam logic [DATA_W-1:0] STEP_MSB = 16'h8000;
  localparam logic [DATA_W-1:0] STEP_LSB = 16'h0001;
  localparam logic [DATA_W-1:0] CODE_ZERO = 16'h0000;

  localparam logic signed [IN_W-1:0] SAT_HIGH = 18'sh0_7FFF;
  localparam logic signed [IN_W-1:0] SAT_LOW  = 18'sh3_8000;

  // ----------------------------------------------------------------
  // Converter states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SASR_SLEEP   = 3'b000,
    SASR_CONVERT = 3'b001,
    SASR_PUBLISH = 3'b010,
    SASR_SIGNAL  = 3'b011,
    SASR_PUSH    = 3'b100
  } sasr_state_t;

endpackage : sasr_pkg

// [rtl/sasr_fifo_if.sv]
`timescale 1ns/1ps
interface sasr_fifo_if #(
  parameter int W = 16
);
  logic         wrValid;
  logic         wrReady;
  logic [W-1:0] wrData;
  logic         rdValid;
  logic         rdReady;
  logic [W-1:0] rdData;

  // Converter side fills and the user port drains
  modport ctrl  (output wrValid, output wrData, output rdReady,
                 input wrReady, input rdValid, input rdData);
  modport store (input wrValid, input wrData, input rdReady,
                 output wrReady, output rdValid, output rdData);
endinterface : sasr_fifo_if

// [rtl/sasr_fifo.sv]
`timescale 1ns/1ps
module sasr_fifo
  import sasr_pkg::*;
#(
  parameter int W     = 16,
  parameter int DEPTH = 16
)(
  input wire logic   clock,
  input wire logic   rst_n,
  sasr_fifo_if.store fifoPort
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  localparam logic [AW:0] ONE_CNT  = (AW+1)'(1);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic [AW:0]   count;
  logic          outValid;
  logic [W-1:0]  outData;

  // ----------------------------------------------------------------
  // Handshake decode
  // ----------------------------------------------------------------
  wire push = fifoPort.wrValid && fifoPort.wrReady;
  wire pop  = (count != '0) && (!outValid || fifoPort.rdReady);
  wire [AW:0] next_count = push && !pop ? count + ONE_CNT :
                           !push && pop ? count - ONE_CNT : count;

  assign fifoPort.wrReady = (count != FULL_CNT);
  assign fifoPort.rdValid = outValid;
  assign fifoPort.rdData  = outData;

  // Storage, one flop word per entry; pointers wrap, depth a power of 2
  for (genvar i = 0; i < DEPTH; i++)
  begin : g_entry
    always_ff @(posedge clock)
    begin
      if (push && wrPtr == AW'(i))
        mem[i] <= fifoPort.wrData;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end
    else
    begin
      wrPtr <= push ? wrPtr + AW'(1) : wrPtr;
      rdPtr <= pop ? rdPtr + AW'(1) : rdPtr;
      count <= next_count;
    end
  end

  // Registered head so the user port comes from flops
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      outValid <= 1'b0;
      outData  <= '0;
    end
    else if (pop)
    begin
      outValid <= 1'b1;
      outData  <= mem[rdPtr];
    end
    else if (fifoPort.rdReady)
      outValid <= 1'b0;
  end

endmodule : sasr_fifo

// [rtl/sasr_top.sv]
`timescale 1ns/1ps
module sasr_top
  import sasr_pkg::*;
#(
  parameter int FIFO_W = DATA_W,
  parameter int FIFO_D = FIFO_DEPTH
)(
  input  wire logic                   clock,
  input  wire logic                   rst_n,
  input  wire logic signed [IN_W-1:0] analogIn,
  input  wire logic                   convSelect_n,
  input  wire logic                   serialBitClock,
  output logic                        serialOut,
  output logic                        serialOutEn_n,
  output logic                        powerDown,
  output logic [FIFO_W-1:0]           resultData,
  output logic                        resultValid,
  input  wire logic                   resultReady
);

  // ----------------------------------------------------------------
  // Select synchroniser and edge detect (system clock)
  // ----------------------------------------------------------------
  logic        csSync1;
  logic        csSync2;
  logic        csPrev;
  sasr_state_t state;
  sasr_state_t next_state;
  logic [DATA_W-1:0] heldCode;
  logic [DATA_W-1:0] heldTarget;
  logic [DATA_W-1:0] sarCode;
  logic [DATA_W-1:0] stepBit;
  logic [DATA_W-1:0] resultHold;
  logic              resultRdy;

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      csSync1 <= 1'b1;
      csSync2 <= 1'b1;
      csPrev  <= 1'b1;
    end
    else
    begin
      csSync1 <= convSelect_n;
      csSync2 <= csSync1;
      csPrev  <= csSync2;
    end
  end

  wire csFall = csPrev && !csSync2;

  // Saturation of the held input to the code range
  wire inHigh = analogIn > SAT_HIGH;
  wire inLow  = analogIn < SAT_LOW;
  wire [DATA_W-1:0] satCode = inHigh ? CODE_MAX :       // RULE6
                              inLow  ? CODE_MIN :
                              analogIn[DATA_W-1:0];

  // Successive approximation trial in offset binary
  wire [DATA_W-1:0] trial   = sarCode | stepBit;
  wire              keepBit = trial <= heldTarget;
  wire              lastStep = stepBit == STEP_LSB;

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  sasr_fifo_if #(.W(FIFO_W)) fifoBus ();

  // Next state; an edge while busy is ignored
  always_comb
  begin
    next_state = state;
    case (state)
      SASR_SLEEP:   next_state = csFall ? SASR_CONVERT : SASR_SLEEP; // RULE1
      SASR_CONVERT: next_state = lastStep ? SASR_PUBLISH : SASR_CONVERT;
      SASR_PUBLISH: next_state = SASR_SIGNAL;
      SASR_SIGNAL:  next_state = SASR_PUSH;
      SASR_PUSH:    next_state = fifoBus.wrReady ? SASR_SLEEP : SASR_PUSH;
      default:      next_state = SASR_SLEEP;
    endcase
  end

  // State and power-down flag; asleep whenever the sequencer is idle
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      state     <= SASR_SLEEP;
      powerDown <= 1'b1;
    end
    else
    begin
      state     <= next_state;
      powerDown <= next_state == SASR_SLEEP;                         // RULE5
    end
  end

  // Track and hold on the select edge, then the bit trials
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      heldCode   <= CODE_ZERO;
      heldTarget <= CODE_ZERO;
      sarCode    <= CODE_ZERO;
      stepBit    <= STEP_MSB;
    end
    else if (state == SASR_SLEEP && csFall)
    begin
      heldCode   <= satCode;                                         // RULE7
      heldTarget <= satCode ^ CODE_OFS;
      sarCode    <= CODE_ZERO;
      stepBit    <= STEP_MSB;
    end
    else if (state == SASR_CONVERT)
    begin
      sarCode <= keepBit ? trial : sarCode;
      stepBit <= stepBit >> 1;
    end
  end

  // Result word and its ready level; the level is cleared at each new start so a
  // stale word reaches the link only from a select edge ignored while busy
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      resultHold <= CODE_ZERO;
      resultRdy  <= 1'b0;
    end
    else if (state == SASR_SLEEP && csFall)
      resultRdy  <= 1'b0;                                            // RULE7
    else if (state == SASR_PUBLISH)
      resultHold <= sarCode ^ CODE_OFS;                              // RULE6
    else if (state == SASR_SIGNAL)
      resultRdy  <= 1'b1;
  end

  // ----------------------------------------------------------------
  // Result copy buffer; a full buffer holds the sequencer awake
  // ----------------------------------------------------------------
  assign fifoBus.wrValid = state == SASR_PUSH;
  assign fifoBus.wrData  = resultHold;
  assign fifoBus.rdReady = resultReady;
  assign resultValid     = fifoBus.rdValid;
  assign resultData      = fifoBus.rdData;

  sasr_fifo #(
    .W     (FIFO_W),
    .DEPTH (FIFO_D)
  ) u_fifo (
    .clock    (clock),
    .rst_n    (rst_n),
    .fifoPort (fifoBus.store)
  );

  // ----------------------------------------------------------------
  // Link side, on falling bit clock edges; select high clears it
  // ----------------------------------------------------------------
  logic              rdySync1;
  logic              rdySync2;
  logic [CNT_W-1:0]  edgeCnt;
  logic [DATA_W-1:0] shiftReg;

  wire atFifth  = edgeCnt == FIRST_EDGE - 5'h01;
  wire shifting = edgeCnt >= FIRST_EDGE && edgeCnt < LAST_EDGE;
  // Word is static while the ready level is high, so it may be taken
  wire [DATA_W-1:0] loadWord = rdySync2 ? resultHold : CODE_ZERO;

  // Ready level crossing and edge counter
  always_ff @(negedge serialBitClock or posedge convSelect_n)
  begin
    if (convSelect_n)
    begin
      rdySync1 <= 1'b0;
      rdySync2 <= 1'b0;
      edgeCnt  <= '0;
    end
    else
    begin
      rdySync1 <= resultRdy;
      rdySync2 <= rdySync1;
      edgeCnt  <= edgeCnt == LAST_EDGE ? edgeCnt : edgeCnt + 5'h01;
    end
  end

  // Output changes only on falling edges and at select high, so it is steady over the
  // rising edge and until just after the next falling one
  always_ff @(negedge serialBitClock or posedge convSelect_n)
  begin
    if (convSelect_n)
    begin
      serialOutEn_n <= 1'b1;                                         // RULE8
      serialOut     <= 1'b0;
      shiftReg      <= CODE_ZERO;
    end
    else if (atFifth)
    begin
      serialOutEn_n <= 1'b0;                                         // RULE2
      serialOut     <= 1'b0;
      shiftReg      <= loadWord;
    end
    else if (shifting)
    begin
      serialOut <= shiftReg[DATA_W-1];                               // RULE3 RULE4
      shiftReg  <= shiftReg << 1;
    end
    else
      serialOut <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_fifth;
    atFifth;
  endsequence

  sequence s_first_bit;
    s_fifth ##1 shifting;
  endsequence

  chk_start_on_fall: assert property (                               // RULE1
    @(posedge clock) disable iff (!rst_n)
    state == SASR_SLEEP && csFall |=> state == SASR_CONVERT && !powerDown)
    else $error("conversion did not start on select edge");

  chk_sat_high_code: assert property (                               // RULE6
    @(posedge clock) disable iff (!rst_n)
    state == SASR_SLEEP && csFall && inHigh |=> heldCode == CODE_MAX)
    else $error("overrange did not saturate high");

  chk_sat_low_code: assert property (                                // RULE6
    @(posedge clock) disable iff (!rst_n)
    state == SASR_SLEEP && csFall && inLow |=> heldCode == CODE_MIN)
    else $error("underrange did not saturate low");

  chk_same_sample: assert property (                                 // RULE7
    @(posedge clock) disable iff (!rst_n)
    state == SASR_SLEEP && csFall |=>
      !resultRdy ##18 resultRdy && resultHold == heldCode)
    else $error("result is not the sample of this edge");

  chk_auto_sleep: assert property (                                  // RULE5
    @(posedge clock) disable iff (!rst_n)
    state == SASR_PUSH && fifoBus.wrReady |=> powerDown
      && state == SASR_SLEEP)
    else $error("converter did not power down");

  // A full buffer must hold the word in the sequencer, awake
  chk_full_stall: assert property (                                  // RULE5
    @(posedge clock) disable iff (!rst_n)
    state == SASR_PUSH && !fifoBus.wrReady |=>
      state == SASR_PUSH && !powerDown)
    else $error("full buffer dropped a result or slept");

  chk_off_early: assert property (                                   // RULE2
    @(negedge serialBitClock) disable iff (convSelect_n)
    edgeCnt < FIRST_EDGE - 5'h01 |=> serialOutEn_n)
    else $error("output enabled before fifth edge");

  chk_low_at_fifth: assert property (                                // RULE2
    @(negedge serialBitClock) disable iff (convSelect_n)
    s_fifth |=> !serialOutEn_n && !serialOut)
    else $error("output not driven low at fifth edge");

  chk_msb_first: assert property (                                   // RULE3
    @(negedge serialBitClock) disable iff (convSelect_n)
    s_first_bit |=> serialOut == $past(loadWord[DATA_W-1], 2))
    else $error("first bit is not the msb");

  chk_release_out: assert property (                                 // RULE8
    @(posedge clock) disable iff (!rst_n)
    csSync2 |-> serialOutEn_n)
    else $error("output not released with select high");

endmodule : sasr_top

// [dv/sasr_host_model.sv]
`timescale 1ns/1ps
// --------------------------------------------------------------
// Host side of the serial readout port
// --------------------------------------------------------------
module sasr_host_model (
  output logic      convSelect_n,
  output logic      serialBitClock,
  input  wire logic serialOut,
  input  wire logic serialOutEn_n
);
  localparam int HALF    = 24;
  localparam int N_FALLS = 22;

  // Bit clock parks high so no stray falling edge reaches the link
  // A short low pulse gives select one clean rising edge at start, so
  // the link flops leave the unknown state before any frame
  initial
  begin
    convSelect_n   = 1'b0;
    serialBitClock = 1'b1;
    #1;
    convSelect_n   = 1'b1;
  end

  // One frame: select low, 22 falls, bits taken at the end of each low phase
  task automatic run_frame(output logic [15:0] word, output logic ok);
    logic a;
    word = 16'h0000;
    ok   = 1'b1;
    convSelect_n = 1'b0;
    #10;
    for (int k = 1; k <= N_FALLS; k++)
    begin
      serialBitClock = 1'b0;
      #HALF;
      a = serialOut;
      if (k < 5)
        ok = ok & (serialOutEn_n === 1'b1);
      else
        ok = ok & (serialOutEn_n === 1'b0);
      if (k == 5 || k == N_FALLS)
        ok = ok & (a === 1'b0);
      if (k >= 6 && k <= 21)
        word = {word[14:0], a};
      serialBitClock = 1'b1;
      #HALF;
      // Bit must still stand just before the next fall
      if (serialOut !== a) ok = 1'b0;
    end
    // Select held low until every bit is in
    convSelect_n = 1'b1;
  endtask : run_frame
endmodule : sasr_host_model

// [dv/testbench.sv]
`timescale 1ns/1ps
module testbench;
  import sasr_pkg::*;
  localparam int LIMIT = 30000;
  logic                   clock;
  logic                   rst_n;
  logic signed [IN_W-1:0] analogIn;
  logic                   convSelect_n;
  logic                   serialBitClock;
  logic                   serialOut;
  logic                   serialOutEn_n;
  logic                   powerDown;
  logic [DATA_W-1:0]      resultData;
  logic                   resultValid;
  logic                   resultReady;
  logic                   drainOn = 1'b0;
  logic [15:0]            lfsr = 16'h0052;
  logic [DATA_W-1:0]      expQ[$];
  int                     nMismatch;
  int                     checksDone;
  int                     cycles;
  int                     nPopped;
  logic signed [IN_W-1:0] tbl[8];

  sasr_top sasr_top_i (
    .clock(clock), .rst_n(rst_n), .analogIn(analogIn),
    .convSelect_n(convSelect_n), .serialBitClock(serialBitClock),
    .serialOut(serialOut), .serialOutEn_n(serialOutEn_n),
    .powerDown(powerDown), .resultData(resultData),
    .resultValid(resultValid), .resultReady(resultReady)
  );
  sasr_host_model sasr_host_model_i (
    .convSelect_n(convSelect_n), .serialBitClock(serialBitClock),
    .serialOut(serialOut), .serialOutEn_n(serialOutEn_n)
  );

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  // Out of range inputs clip to the end codes
  function automatic logic [15:0] sat(input int v);
    if (v > 32767) return 16'h7FFF;
    if (v < -32768) return 16'h8000;
    return v[15:0];
  endfunction : sat

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    checksDone++;
    if (seen !== exp)
    begin
      nMismatch++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic final_report;
    $display("checks %0d mismatches %0d", checksDone, nMismatch);
    if (nMismatch == 0 && checksDone > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report

  // One conversion; a stuck frame has no room in the buffer
  task automatic do_frame(input logic signed [IN_W-1:0] v, input bit stuck);
    logic [15:0] w;
    logic        ok;
    @(negedge clock);
    analogIn = v;
    expQ.push_back(sat(int'(v)));
    sasr_host_model_i.run_frame(w, ok);
    check("linkWord", {16'h0000, w}, {16'h0000, sat(int'(v))});
    check("linkFrame", {31'h0, ok}, 32'h1);
    #1 check("outEnable", {31'h0, serialOutEn_n}, 32'h1);
    repeat (40) @(negedge clock);
    if (!stuck)
      check("powerDown", {31'h0, powerDown}, 32'h1);
  endtask : do_frame

  task automatic wait_drain;
    for (int t = 0; t < 3000 && expQ.size() > 0; t++)
      @(negedge clock);
    repeat (50) @(negedge clock);
    check("drained", expQ.size(), 32'h0);
  endtask : wait_drain

  // --------------------------------------------------------------
  // Clock, random ready, reference compare, hang guard
  // --------------------------------------------------------------
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  always @(negedge clock)
  begin
    lfsr        <= lfsr_next(lfsr);
    resultReady <= drainOn & lfsr[0];
  end

  // Every word handed over must match the model queue head
  always @(posedge clock)
  begin
    if (rst_n === 1'b1 && resultValid === 1'b1 && resultReady === 1'b1)
    begin
      nPopped++;
      if (expQ.size() == 0)
        check("extraWord", 32'h1, 32'h0);
      else
        check("resultData", resultData, expQ.pop_front());
    end
    cycles++;
    if (cycles >= LIMIT)
    begin
      nMismatch++;
      final_report();
    end
  end

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial
  begin
    tbl = '{18'sh0_0000, 18'sh3_FFFF, 18'sh0_7FFF, 18'sh0_8000,
            18'sh3_8000, 18'sh3_7FFF, 18'sh1_FFFF, 18'sh2_0000};
    rst_n       = 1'b0;
    analogIn    = '0;
    resultReady = 1'b0;
    drainOn     = 1'b0;
    nMismatch   = 0;
    checksDone  = 0;
    cycles      = 0;
    nPopped     = 0;
    // Count rising edges; the first falling event at time zero is racy
    repeat (5) @(posedge clock);
    @(negedge clock);
    rst_n = 1'b1;
    repeat (3) @(negedge clock);
    // Fill: 17 words fit, the 18th waits in the converter
    for (int i = 0; i < 18; i++)
      do_frame(i < 8 ? tbl[i] : $signed({lfsr[15:14], lfsr}), i == 17);
    repeat (100) @(negedge clock);
    check("stuckPower", {31'h0, powerDown}, 32'h0);
    check("fullValid", {31'h0, resultValid}, 32'h1);
    drainOn = 1'b1;
    wait_drain();
    check("idlePower", {31'h0, powerDown}, 32'h1);
    // Streaming with the drain stalling at random
    for (int i = 0; i < 12; i++)
      do_frame($signed({lfsr[15:14], lfsr}), 1'b0);
    wait_drain();
    check("wordCount", nPopped, 32'd30);
    final_report();
  end
endmodule : testbench
